// ===== src/tlq_consts.svh
// Named constants for the link transmitter clock, lane and video block.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef TLQ_CONSTS_SVH
`define TLQ_CONSTS_SVH

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define TLQ_ADDR_W 8
`define TLQ_REG_CTRL 8'h00
`define TLQ_REG_STATUS 8'h04
`define TLQ_REG_VIDCNT 8'h08
`define TLQ_CTRL_RST 32'h0000_0000
`define TLQ_CTRL_MASK 32'h0000_00FF

// ----------------------------------------
// Clock-channel words
// ----------------------------------------
`define TLQ_CW_LO_RATIO 10'h3E0
`define TLQ_CW_ZERO10 10'h000
`define TLQ_CW_ONES10 10'h3FF
`define TLQ_CW_ZERO20 20'h00000
`define TLQ_CW_ONES20 20'hFFFFF

// ----------------------------------------
// Lane and character layout
// ----------------------------------------
`define TLQ_LANE_W 40
`define TLQ_LANES 4
`define TLQ_CHAR_W 18
`define TLQ_CHARS 16
`define TLQ_PIX_W 24
`define TLQ_PPC_TMDS 2
`define TLQ_PPC_FRL 8
`define TLQ_TAG_DATA 2'h1
`define TLQ_TAG_GAP 2'h2
`define TLQ_FRL_RATE_3LANE 3'h2

// ----------------------------------------
// Training patterns
// ----------------------------------------
`define TLQ_PAT_ZERO 4'h0
`define TLQ_PAT_ONES 4'h1
`define TLQ_PAT_ALT 4'h2
`define TLQ_PAT_PRBS 4'h3
`define TLQ_PAT_CLOCK 4'h4
`define TLQ_ALT_WORD 40'hAA_AAAA_AAAA
`define TLQ_CLOCK_WORD 40'hFF_FFF0_0000
`define TLQ_LFSR_SEED 16'hACE1
`define TLQ_LFSR_TAPS 16'hB400

// ----------------------------------------
// Audio slots
// ----------------------------------------
`define TLQ_AUD_SLOT_W 32
`define TLQ_AUD_SLOTS 8
`define TLQ_AUD_LAST 3'h7

`endif

// ===== src/tlq_pkg.sv
// Types shared by the link transmitter clock, lane and video block.
// Assumes nothing beyond a SystemVerilog compiler.
package tlq_pkg;

  // ----------------------------------------
  // Modes and states
  // ----------------------------------------
  typedef enum logic [1:0] {
    TLQ_SYM1 = 2'b00,
    TLQ_SYM2 = 2'b01,
    TLQ_SYM4 = 2'b10
  } tlq_sym_e;

  typedef enum logic [1:0] {
    TLQ_PH0 = 2'b00,
    TLQ_PH1 = 2'b01,
    TLQ_PH2 = 2'b10,
    TLQ_PH3 = 2'b11
  } tlq_phase_e;

  typedef enum logic [0:0] {
    TLQ_AUD_IDLE = 1'b0,
    TLQ_AUD_WALK = 1'b1
  } tlq_aud_e;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic aud_multi;
    logic [2:0] frl_rate;
    logic frl_en;
    tlq_sym_e sym_mode;
    logic high_bit_ratio_flag;
  } tlq_ctrl_s;

  typedef struct packed {
    logic [39:0] lane3;
    logic [39:0] lane2;
    logic [39:0] lane1;
    logic [39:0] lane0;
  } tlq_lanes_s;

  typedef struct packed {
    logic multi_stream;
    logic [5:0] channel;
    logic [2:0] stream;
    logic right;
  } tlq_aud_tag_s;

endpackage : tlq_pkg

// ===== src/tlq_clk_pattern.sv
// Clock-channel word generator for the symbol-mode link.
// Assumes the ratio and symbol settings are stable while in use.
`timescale 1ns/1ns
`default_nettype none
`include "tlq_consts.svh"

module tlq_clk_pattern (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic high_bit_ratio_flag,
  input wire tlq_pkg::tlq_sym_e sym_mode,
  output logic [39:0] clk_word
);
  import tlq_pkg::*;

  tlq_phase_e phase;
  logic [39:0] next_clk_word;

  // ----------------------------------------
  // Four-step phase
  // ----------------------------------------
  // Restarts at step one, advances every cycle
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase <= TLQ_PH0;
    end else begin
      case (phase)
        TLQ_PH0: phase <= TLQ_PH1;
        TLQ_PH1: phase <= TLQ_PH2;
        TLQ_PH2: phase <= TLQ_PH3;
        TLQ_PH3: phase <= TLQ_PH0;
        default: phase <= TLQ_PH0;
      endcase
    end
  end

  // ----------------------------------------
  // Word selection
  // ----------------------------------------
  // Narrow words sit in the low bits; upper bits stay zero
  always_comb begin
    next_clk_word = '0;
    if (high_bit_ratio_flag) begin
      case (sym_mode)
        TLQ_SYM1: next_clk_word[9:0] = phase[1] ? `TLQ_CW_ONES10 : `TLQ_CW_ZERO10;
        TLQ_SYM2: next_clk_word[19:0] = phase[0] ? `TLQ_CW_ONES20 : `TLQ_CW_ZERO20;
        TLQ_SYM4: next_clk_word = {`TLQ_CW_ONES20, `TLQ_CW_ZERO20};
        default: next_clk_word = '0;
      endcase
    end else begin
      case (sym_mode)
        TLQ_SYM1: next_clk_word[9:0] = `TLQ_CW_LO_RATIO;
        TLQ_SYM2: next_clk_word[19:0] = {2{`TLQ_CW_LO_RATIO}};
        TLQ_SYM4: next_clk_word = {4{`TLQ_CW_LO_RATIO}};
        default: next_clk_word = '0;
      endcase
    end
  end

  // Registered so the lane sees a clean word
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clk_word <= '0;
    end else begin
      clk_word <= next_clk_word;
    end
  end

endmodule : tlq_clk_pattern
`default_nettype wire

// ===== src/tlq_frl_pack.sv
// Character-to-lane gearbox for the fixed-rate-link path.
// Assumes the lane count only changes while the path is idle.
`timescale 1ns/1ns
`default_nettype none
`include "tlq_consts.svh"

module tlq_frl_pack #(
  parameter int CHAR_W = `TLQ_CHAR_W,
  parameter int CHARS = `TLQ_CHARS,
  parameter int LANE_W = `TLQ_LANE_W,
  parameter int LANES = `TLQ_LANES
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic all_lanes,
  input wire logic in_valid,
  input wire logic [CHARS*CHAR_W-1:0] in_chars,
  output logic in_ready,
  output logic out_valid,
  output logic [LANES*LANE_W-1:0] out_data
);
  import tlq_pkg::*;

  localparam int IN_W = CHARS * CHAR_W;
  localparam int OUT_W = LANES * LANE_W;
  localparam int BUF_W = IN_W + OUT_W;
  localparam int FILL_W = $clog2(BUF_W + 1);
  localparam logic [FILL_W-1:0] FULL_NEED = FILL_W'(OUT_W);
  localparam logic [FILL_W-1:0] LESS_NEED = FILL_W'(OUT_W - LANE_W);
  localparam logic [FILL_W-1:0] IN_BITS = FILL_W'(IN_W);
  localparam logic [FILL_W-1:0] ROOM = FILL_W'(BUF_W - IN_W);

  logic [BUF_W-1:0] bits;
  logic [FILL_W-1:0] fill;
  logic [FILL_W-1:0] need;
  logic [FILL_W-1:0] left;
  logic take;
  logic accept;
  logic [BUF_W-1:0] next_bits;

  // ----------------------------------------
  // Drain and fill decision
  // ----------------------------------------
  // Three-lane rates drain one lane less per cycle
  assign need = all_lanes ? FULL_NEED : LESS_NEED;
  assign take = (fill >= need);
  assign left = take ? fill - need : fill;
  // Stall upstream rather than overwrite unsent bits
  assign in_ready = (left <= ROOM);
  assign accept = in_valid && in_ready;

  // Oldest bits sit at the bottom of the buffer
  always_comb begin
    next_bits = take ? (bits >> need) : bits;
    if (accept) begin
      next_bits = next_bits | (BUF_W'(in_chars) << left);
    end
  end

  // ----------------------------------------
  // Buffer state
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bits <= '0;
      fill <= '0;
    end else begin
      bits <= next_bits;
      fill <= accept ? left + IN_BITS : left;
    end
  end

  // Unused fourth lane is driven to zero
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else begin
      out_valid <= take;
      if (!take) begin
        out_data <= '0;
      end else if (all_lanes) begin
        out_data <= bits[OUT_W-1:0];
      end else begin
        out_data <= {{LANE_W{1'b0}}, bits[OUT_W-LANE_W-1:0]};
      end
    end
  end

endmodule : tlq_frl_pack
`default_nettype wire

// ===== src/tlq_top.sv
// Link transmitter clock-channel, training, lane and video-qualify block.
// Assumes one clock for all paths and a register master per the port below.
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "tlq_consts.svh"

module tlq_top #(
  parameter int LANE_W = `TLQ_LANE_W,
  parameter int LANES = `TLQ_LANES,
  parameter int PIX_W = `TLQ_PIX_W,
  parameter int PPC_MAX = `TLQ_PPC_FRL,
  parameter int CHARS = `TLQ_CHARS
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic vid_valid,
  input wire logic [PPC_MAX*PIX_W-1:0] vid_data,
  output logic vid_ready,
  input wire logic train_start,
  input wire logic [4*LANES-1:0] pattern_select,
  input wire logic aud_valid,
  input wire logic [255:0] aud_data,
  input wire logic [1:0] aud_group,
  output logic aud_ready,
  output logic aud_out_valid,
  output logic [31:0] aud_out_sample,
  output tlq_pkg::tlq_aud_tag_s aud_out_tag,
  output tlq_pkg::tlq_lanes_s tx_lanes
);
  import tlq_pkg::*;

  localparam int VID_W = PPC_MAX * PIX_W;
  localparam int PAY_W = `TLQ_CHAR_W - 2;

  tlq_ctrl_s ctrl;
  logic [31:0] vid_count;
  logic [VID_W-1:0] vid_word;
  logic vid_fresh;
  logic [39:0] clk_word;
  logic [CHARS*`TLQ_CHAR_W-1:0] frl_chars;
  logic frl_ready;
  logic frl_out_valid;
  logic [LANES*LANE_W-1:0] frl_out;
  logic all_lanes;
  logic [LANES*LANE_W-1:0] train_word;
  logic [LANES*16-1:0] lfsr;
  logic [LANES*LANE_W-1:0] sym_word;
  tlq_lanes_s next_lanes;
  tlq_aud_e aud_state;
  logic [2:0] aud_slot;
  logic [255:0] aud_hold;
  logic [1:0] aud_grp_hold;
  logic aud_multi_hold;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // One training word per lane from its select code
  function automatic logic [39:0] pattern_word(input logic [3:0] sel, input logic [15:0] prbs);
    case (sel)
      `TLQ_PAT_ZERO: pattern_word = '0;
      `TLQ_PAT_ONES: pattern_word = '1;
      `TLQ_PAT_ALT: pattern_word = `TLQ_ALT_WORD;
      `TLQ_PAT_PRBS: pattern_word = {prbs[7:0], prbs, prbs};
      `TLQ_PAT_CLOCK: pattern_word = `TLQ_CLOCK_WORD;
      default: pattern_word = '0;
    endcase
  endfunction : pattern_word

  // Pick one 32-bit slot of the audio bus
  function automatic logic [31:0] aud_slot_word(input logic [255:0] bus, input logic [2:0] idx);
    aud_slot_word = bus[idx*`TLQ_AUD_SLOT_W +: `TLQ_AUD_SLOT_W];
  endfunction : aud_slot_word

  // ----------------------------------------
  // Register write
  // ----------------------------------------
  // Only the control register is writable; other writes are dropped
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl <= tlq_ctrl_s'(`TLQ_CTRL_RST);
    end else if (reg_wr && reg_addr == `TLQ_REG_CTRL) begin
      ctrl <= tlq_ctrl_s'(reg_wdata[$bits(tlq_ctrl_s)-1:0]);
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        `TLQ_REG_CTRL: reg_rdata <= 32'(ctrl);
        `TLQ_REG_STATUS: reg_rdata <= {28'h0000000, all_lanes, frl_out_valid, ctrl.frl_en,
                                       !train_start};
        `TLQ_REG_VIDCNT: reg_rdata <= vid_count;
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // ----------------------------------------
  // Video qualification
  // ----------------------------------------
  // Back-pressure only exists on the link path, where the gearbox can fill
  assign vid_ready = ctrl.frl_en ? frl_ready : 1'b1;

  // Word is taken only on a valid cycle; idle cycles leave it untouched
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      vid_word <= '0;
      vid_fresh <= 1'b0;
    end else begin
      vid_fresh <= vid_valid && vid_ready;
      if (vid_valid && vid_ready) begin
        if (ctrl.frl_en) begin
          vid_word <= vid_data;
        end else begin
          vid_word <= VID_W'(vid_data[`TLQ_PPC_TMDS*PIX_W-1:0]);
        end
      end
    end
  end

  // Count of accepted words, visible to software
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      vid_count <= '0;
    end else if (vid_valid && vid_ready) begin
      vid_count <= vid_count + 32'h0000_0001;
    end
  end

  // ----------------------------------------
  // Symbol-mode lanes
  // ----------------------------------------
  // Each data lane carries one colour of both pixels; encoding sits downstream
  generate
    for (genvar l = 0; l < LANES; l++) begin : g_sym
      if (l < 3) begin : g_data
        assign sym_word[l*LANE_W +: LANE_W] = {{(LANE_W-16){1'b0}},
          vid_word[PIX_W + l*8 +: 8], vid_word[l*8 +: 8]};
      end else begin : g_clock
        assign sym_word[l*LANE_W +: LANE_W] = clk_word;
      end
    end
  endgenerate

  tlq_clk_pattern u_clk_pattern (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .high_bit_ratio_flag(ctrl.high_bit_ratio_flag),
    .sym_mode(ctrl.sym_mode),
    .clk_word(clk_word)
  );

  // ----------------------------------------
  // Fixed-rate-link characters
  // ----------------------------------------
  // Pixels fill the first characters; the rest are gap characters
  generate
    for (genvar c = 0; c < CHARS; c++) begin : g_char
      if ((c + 1) * PAY_W <= VID_W) begin : g_pay
        assign frl_chars[c*`TLQ_CHAR_W +: `TLQ_CHAR_W] =
          {`TLQ_TAG_DATA, vid_data[c*PAY_W +: PAY_W]};
      end else begin : g_gap
        assign frl_chars[c*`TLQ_CHAR_W +: `TLQ_CHAR_W] =
          {`TLQ_TAG_GAP, {PAY_W{1'b0}}};
      end
    end
  endgenerate

  // Rates one and two leave the fourth lane idle
  assign all_lanes = (ctrl.frl_rate > `TLQ_FRL_RATE_3LANE);

  tlq_frl_pack #(
    .CHAR_W(`TLQ_CHAR_W),
    .CHARS(CHARS),
    .LANE_W(LANE_W),
    .LANES(LANES)
  ) u_frl_pack (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .all_lanes(all_lanes),
    .in_valid(vid_valid && ctrl.frl_en),
    .in_chars(frl_chars),
    .in_ready(frl_ready),
    .out_valid(frl_out_valid),
    .out_data(frl_out)
  );

  // ----------------------------------------
  // Training patterns
  // ----------------------------------------
  // One free-running scrambler per lane, seeded apart by lane number
  generate
    for (genvar l = 0; l < LANES; l++) begin : g_train
      always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          lfsr[l*16 +: 16] <= `TLQ_LFSR_SEED ^ 16'(l);
        end else begin
          lfsr[l*16 +: 16] <= {1'b0, lfsr[l*16+1 +: 15]} ^
            (lfsr[l*16] ? `TLQ_LFSR_TAPS : 16'h0000);
        end
      end
      assign train_word[l*LANE_W +: LANE_W] =
        pattern_word(pattern_select[l*4 +: 4], lfsr[l*16 +: 16]);
    end
  endgenerate

  // ----------------------------------------
  // Lane output selection
  // ----------------------------------------
  // Training overrides both paths; the idle path is never looked at
  always_comb begin
    if (!train_start) begin
      next_lanes = tlq_lanes_s'(train_word);
    end else if (ctrl.frl_en) begin
      next_lanes = tlq_lanes_s'(frl_out);
    end else begin
      next_lanes = tlq_lanes_s'(sym_word);
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_lanes <= '0;
    end else begin
      tx_lanes <= next_lanes;
    end
  end

  // ----------------------------------------
  // Audio slot walk
  // ----------------------------------------
  // A bus word is held and walked one slot per cycle, lowest first
  assign aud_ready = (aud_state == TLQ_AUD_IDLE);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      aud_state <= TLQ_AUD_IDLE;
      aud_slot <= '0;
      aud_hold <= '0;
      aud_grp_hold <= '0;
      aud_multi_hold <= 1'b0;
    end else begin
      case (aud_state)
        TLQ_AUD_IDLE: begin
          if (aud_valid) begin
            aud_state <= TLQ_AUD_WALK;
            aud_slot <= '0;
            aud_hold <= aud_data;
            aud_grp_hold <= aud_group;
            aud_multi_hold <= ctrl.aud_multi;
          end
        end
        TLQ_AUD_WALK: begin
          aud_slot <= aud_slot + 3'h1;
          if (aud_slot == `TLQ_AUD_LAST) begin
            aud_state <= TLQ_AUD_IDLE;
          end
        end
        default: aud_state <= TLQ_AUD_IDLE;
      endcase
    end
  end

  // Tag each sample with its channel, or stream and side
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      aud_out_valid <= 1'b0;
      aud_out_sample <= '0;
      aud_out_tag <= '0;
    end else if (aud_state == TLQ_AUD_WALK) begin
      aud_out_valid <= 1'b1;
      aud_out_sample <= aud_slot_word(aud_hold, aud_slot);
      aud_out_tag.multi_stream <= aud_multi_hold;
      aud_out_tag.channel <= aud_multi_hold ? 6'h00 :
        {1'b0, aud_grp_hold, aud_slot} + 6'h01;
      aud_out_tag.stream <= aud_multi_hold ? {1'b0, aud_slot[2:1]} + 3'h1 : 3'h0;
      aud_out_tag.right <= aud_multi_hold && aud_slot[0];
    end else begin
      aud_out_valid <= 1'b0;
      aud_out_sample <= '0;
      aud_out_tag <= '0;
    end
  end

endmodule : tlq_top
`default_nettype wire

// ===== test/tlq_monitor.sv
// Port checker for tlq_top.
// Assumes a bind to tlq_top; control is shadowed from register writes.
`timescale 1ns/1ns
`default_nettype none

module tlq_monitor #(
  parameter int LANES = 4
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic vid_valid,
  input wire logic train_start,
  input wire logic [4*LANES-1:0] pattern_select,
  input wire logic aud_valid,
  input wire logic aud_ready,
  input wire logic aud_out_valid,
  input wire tlq_pkg::tlq_lanes_s tx_lanes
);
  logic [7:0] ctrl;
  logic [3:0] steady;
  logic run;
  // Control shadow for mode-dependent checks
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) ctrl <= 8'h00;
    else if (reg_wr && reg_addr == 8'h00) ctrl <= reg_wdata[7:0];
  end
  // Pipelines settle a few cycles after any change
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst || !train_start || (reg_wr && reg_addr == 8'h00)) steady <= 4'h0;
    else if (steady != 4'hF) steady <= steady + 4'h1;
  end
  assign run = steady >= 4'h6 && !ctrl[3];

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence aud_take_s; aud_valid && aud_ready; endsequence
  sequence aud_burst_s; ##1 aud_out_valid [*8]; endsequence

  rd_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not idle");
  rd_unmapped_a: assert property (reg_rd && reg_addr > 8'h08 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  clk_seq1_a: assert property (run && ctrl[2:0] == 3'h1 |->
    tx_lanes.lane3[9:0] == ~$past(tx_lanes.lane3[9:0], 2)) else $error("clock word, 1 sym");
  clk_seq2_a: assert property (run && ctrl[2:0] == 3'h3 |->
    tx_lanes.lane3[19:0] == ~$past(tx_lanes.lane3[19:0])) else $error("clock word, 2 sym");
  clk_word4_a: assert property (run && ctrl[2:0] == 3'h5 |->
    tx_lanes.lane3 == 40'hFFFFF00000) else $error("clock word, 4 sym");
  clk_low_a: assert property (run && ctrl[2:0] == 3'h0 |->
    tx_lanes.lane3[9:0] == 10'h3E0) else $error("clock word, low ratio");
  train_ones_a: assert property (!train_start && pattern_select[7:4] == 4'h1 |=>
    tx_lanes.lane1 == {40{1'b1}}) else $error("training pattern wrong");
  vid_hold_a: assert property (run && !$past(vid_valid, 2) |->
    $stable(tx_lanes.lane0)) else $error("lane moved without valid word");
  lane_spare_a: assert property (steady >= 4'h6 && ctrl[3] &&
    (ctrl[6:4] == 3'h1 || ctrl[6:4] == 3'h2) |-> tx_lanes.lane3 == 40'h0)
    else $error("fourth lane used");
  aud_busy_a: assert property (aud_take_s |=> !aud_ready [*7])
    else $error("audio taken while walking");
  aud_burst_a: assert property (aud_take_s |=> aud_burst_s)
    else $error("audio burst short");
endmodule : tlq_monitor

`default_nettype wire

// ===== test/tlq_vid_source.sv
// Video source partner: offers a word a set number of times.
// Assumes one clock with the block; filler cycles carry the inverted word.
`timescale 1ns/1ns
`default_nettype none

module tlq_vid_source (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic go,
  input wire logic gap,
  input wire logic [3:0] count,
  input wire logic [191:0] word,
  input wire logic vid_ready,
  output logic vid_valid,
  output logic [191:0] vid_data,
  output logic busy
);
  logic [3:0] left;
  logic ph;
  // Busy acts as the inverted empty flag of a source FIFO; gap masks valid on alternate cycles
  assign busy = left != 4'h0;
  assign vid_valid = busy && (!gap || ph);
  assign vid_data = vid_valid ? word : ~word;
  // Offered word is held until the block takes it
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      left <= 4'h0;
      ph <= 1'b0;
    end else begin
      ph <= (vid_valid && !vid_ready) ? ph : !ph;
      if (go) left <= count;
      else if (vid_valid && vid_ready) left <= left - 4'h1;
    end
  end
endmodule : tlq_vid_source

`default_nettype wire

// ===== test/tb.sv
// Bench for tlq_top: registers, training, clock lane, video, audio, link lanes.
// Assumes tlq_vid_source as video partner and tlq_monitor bound below.
// No slow-rate bit repeat is modelled
`timescale 1ns/1ns
`default_nettype none

module tb;
  import tlq_pkg::*;
  localparam int LANES = 4;
  localparam logic [191:0] LW = {12{16'h5A3C}};
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic go = 1'b0;
  logic gap = 1'b0;
  logic [3:0] count = 4'h0;
  logic [191:0] word = 192'h0;
  logic train_start = 1'b0;
  logic [15:0] pattern_select = 16'h0;
  logic aud_valid = 1'b0;
  logic [255:0] aud_data = 256'h0;
  logic [1:0] aud_group = 2'h0;
  logic [31:0] reg_rdata, aud_out_sample;
  logic [191:0] vid_data;
  logic vid_valid, vid_ready, busy, aud_ready, aud_out_valid;
  logic [39:0] p;
  logic [9:0] s [4];
  tlq_aud_tag_s aud_out_tag;
  tlq_lanes_s tx_lanes;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;

  always #2 core_clk = ~core_clk;

  tlq_top tlq_top_inst (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .vid_valid(vid_valid), .vid_data(vid_data), .vid_ready(vid_ready),
    .train_start(train_start), .pattern_select(pattern_select), .aud_valid(aud_valid),
    .aud_data(aud_data), .aud_group(aud_group), .aud_ready(aud_ready),
    .aud_out_valid(aud_out_valid), .aud_out_sample(aud_out_sample),
    .aud_out_tag(aud_out_tag), .tx_lanes(tx_lanes));
  tlq_vid_source tlq_vid_source_inst (.core_clk(core_clk), .sys_rst(sys_rst), .go(go),
    .gap(gap), .count(count), .word(word), .vid_ready(vid_ready), .vid_valid(vid_valid),
    .vid_data(vid_data), .busy(busy));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic waitc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : waitc
  // Spare cycle after each write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    waitc(1);
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(64'(reg_rdata & m), 64'(e));
    waitc(1);
  endtask : rchk
  task automatic do_reset();
    sys_rst <= 1'b1;
    waitc(5);
    sys_rst <= 1'b0;
    waitc(1);
  endtask : do_reset
  task automatic send(input logic [191:0] w, input logic g, input logic [3:0] n);
    word <= w;
    gap <= g;
    count <= n;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    waitc(1);
  endtask : send
  // One audio word; valid outstays the take
  task automatic aud_run(input logic multi, input logic [1:0] g);
    logic [255:0] d;
    for (int i = 0; i < 8; i++) d[i*32+:32] = 32'hA500_0000 + 32'(i * 17 + g);
    wr(8'h00, {24'h0, multi, 7'h0});
    chk(64'(aud_ready), 64'h1);
    aud_data <= d;
    aud_group <= g;
    aud_valid <= 1'b1;
    waitc(2);
    aud_valid <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      chk(64'({aud_out_valid, aud_out_sample}), {31'h0, 1'b1, d[i*32+:32]});
      if (multi) chk(64'(aud_out_tag), 64'({1'b1, 6'h0, 3'(i / 2 + 1), 1'(i % 2)}));
      else chk(64'(aud_out_tag[10:4]), 64'(g * 8 + i + 1));
      if (i == 5) aud_data <= ~d;
      waitc(1);
    end
    chk(64'(aud_out_valid), 64'h0);
  endtask : aud_run
  task automatic frl_run(input logic [2:0] rate);
    do_reset();
    wr(8'h00, {25'h0, rate, 4'h8});
    send(LW, 1'b0, 4'h1);
    for (int i = 0; i < 30 && tx_lanes.lane0 == 40'h0; i++) waitc(1);
    chk(64'(tx_lanes.lane0[17:0]), 64'({2'b01, LW[15:0]}));
    chk(64'(tx_lanes.lane3[5:0]), (rate > 3'h2) ? 64'h15 : 64'h0);
    waitc(4);
  endtask : frl_run
  task automatic stop_test();
    $display("%0d checks, %0d mismatches", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  // Hang guard, far above the run length
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      stop_test();
    end
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    do_reset();
    rchk(8'h00, '1, 32'h0);
    rchk(8'h04, 32'h7, 32'h1);
    rchk(8'h08, '1, 32'h0);
    rchk(8'h0C, '1, 32'h0);
    wr(8'h04, 32'hF);
    rchk(8'h04, 32'h7, 32'h1);
    wr(8'h00, '1);
    rchk(8'h00, '1, 32'hFF);
    wr(8'h00, 32'h0);
    $display("test registers done");
    pattern_select <= 16'h4210;
    waitc(3);
    chk(64'(tx_lanes.lane0), 64'h0);
    chk(64'(tx_lanes.lane1), 64'hFF_FFFF_FFFF);
    chk(64'(tx_lanes.lane2), 64'hAA_AAAA_AAAA);
    chk(64'(tx_lanes.lane3), 64'hFF_FFF0_0000);
    pattern_select <= 16'h0530;
    waitc(3);
    p = tx_lanes.lane1;
    waitc(1);
    chk(64'(tx_lanes.lane1 != p && tx_lanes.lane2 == 40'h0), 64'h1);
    train_start <= 1'b1;
    $display("test training done");
    wr(8'h00, 32'h5);
    waitc(6);
    chk(64'(tx_lanes.lane3), 64'hFF_FFF0_0000);
    wr(8'h00, 32'h3);
    waitc(6);
    p = tx_lanes.lane3;
    waitc(1);
    chk(64'({p[19:0], tx_lanes.lane3[19:0]} inside {40'hFFFFF,
      40'hFFFFF00000}), 64'h1);
    wr(8'h00, 32'h1);
    waitc(6);
    for (int i = 0; i < 4; i++) begin
      s[i] = tx_lanes.lane3[9:0];
      waitc(1);
    end
    chk(64'({s[0], s[1], s[2], s[3]} inside {40'h00000FFFFF, 40'h003FFFFC00,
      40'hFFFFF00000, 40'hFFC00003FF}), 64'h1);
    wr(8'h00, 32'h0);
    waitc(6);
    chk(64'(tx_lanes.lane3[9:0]), 64'h3E0);
    $display("test clock lane done");
    send({144'h0, 48'hA1B2C3_D4E5F6}, 1'b1, 4'h2);
    for (int i = 0; i < 20 && busy; i++) waitc(1);
    waitc(3);
    chk(64'(tx_lanes[119:0]), 64'h00B2E5_0000_00C3F6);
    chk(64'(tx_lanes.lane2), 64'hA1D4);
    rchk(8'h08, '1, 32'h2);
    chk(64'(vid_ready), 64'h1);
    $display("test video done");
    for (int g = 0; g < 4; g++) aud_run(1'b0, 2'(g));
    aud_run(1'b1, 2'h0);
    $display("test audio done");
    frl_run(3'h3);
    frl_run(3'h1);
    $display("test link lanes done");
    stop_test();
  end
endmodule : tb

bind tlq_top tlq_monitor #(.LANES(LANES)) tlq_monitor_inst (.core_clk(core_clk),
  .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .vid_valid(vid_valid),
  .train_start(train_start), .pattern_select(pattern_select), .aud_valid(aud_valid),
  .aud_ready(aud_ready), .aud_out_valid(aud_out_valid), .tx_lanes(tx_lanes));

`default_nettype wire
